// ===== verilog/asm_pkg.sv
// Shared constants and types for the amplifier stage mode and reset control.
package asm_pkg;

    // Mode pin codes, bit 2 is mode_pin_2 and bit 0 is mode_pin_0.
    typedef enum logic [2:0] {
        ASM_BRIDGED_DIFF = 3'b000,
        ASM_BRIDGED_SE = 3'b001,
        ASM_BRIDGED_PAIRED = 3'b010,
        ASM_PARALLEL_DIFF = 3'b100,
        ASM_QUAD_SE = 3'b101
    } asm_mode_t;

    // Register byte addresses.
    localparam logic [7:0] ASM_CTRL_ADDR = 8'h00;
    localparam logic [7:0] ASM_STATUS_ADDR = 8'h04;
    localparam logic [7:0] ASM_EVENT_ADDR = 8'h08;

    // Control register fields and reset value.
    localparam int ASM_CTRL_MUTE_BIT = 0;
    localparam int ASM_CTRL_DCEN_BIT = 1;
    localparam int ASM_CTRL_DIS_LSB = 4;
    localparam logic [31:0] ASM_CTRL_RESET = 32'h0000_0002;

    // Status register fields.
    localparam int ASM_ST_MODE_LSB = 0;
    localparam int ASM_ST_VALID_BIT = 3;
    localparam int ASM_ST_LATCH_BIT = 4;
    localparam int ASM_ST_RUN_BIT = 5;
    localparam int ASM_ST_FPIN_BIT = 6;
    localparam int ASM_ST_STUCK_LSB = 8;

    // Event register: early release flag, write one to clear.
    localparam int ASM_EV_EARLY_BIT = 0;

    // Timing.
    localparam int unsigned ASM_CLK_PERIOD_NS = 50;
    localparam int unsigned ASM_RELEASE_WAIT_NS = 4000000;
    localparam int unsigned ASM_RELEASE_WAIT_CYC =
        (ASM_RELEASE_WAIT_NS + ASM_CLK_PERIOD_NS - 1) / ASM_CLK_PERIOD_NS;
    localparam int unsigned ASM_STUCK_NS = 10000;
    localparam int unsigned ASM_STUCK_CYC =
        ASM_STUCK_NS / ASM_CLK_PERIOD_NS;

endpackage : asm_pkg

// ===== verilog/asm_stage_ctrl.sv
// Mode decode, channel mapping and reset/fault gating of the power stage.
//
// What the document requires of the stage and its controller
// RULE1 - Bridged stereo: two channels, each a differential pair of half-bridges.
// RULE2 - Bridged modes: single-ended input converted to differential drive.
// RULE3 - Paralleled mono: all four half-bridges carry one channel.
// RULE4 - Quad mode: four independent half-bridges, single-ended inputs.
// RULE5 - DC speaker protection acts only with opposite-polarity modulation.
// RULE6 - Modulator supplies paired-state PWM to each differential input pair.
// RULE7 - Modulator drives negative input as inverse of positive input.
// RULE8 - Reset low: every half-bridge transistor off, no switching.
// RULE9 - Reset low in bridged modes: weak pulldown on half-bridge outputs.
// RULE10 - Reset low in quad mode: outputs high impedance, no pulldown.
// RULE11 - Reset low: fault indicator released high whatever the fault.
// RULE12 - Reset rising edge clears latched shutdown and resumes switching.
// RULE13 - Controller waits 4 ms after fault falls before releasing reset.
// RULE14 - Unused channel input tied low so it never switches.
// RULE15 - Three-bit mode code selects input, modulation and output layout.
// RULE16 - Mode code is fixed before start and never changes in operation.
// RULE17 - Global fault stops all switching and latches fault low until reset.
// RULE18 - Channel without PWM edges goes high impedance, resumes on PWM.
// RULE19 - Mode sampled while reset low, held from reset release.
`timescale 1ns/10ps

module asm_stage_ctrl #(
    parameter int unsigned RELEASE_WAIT = asm_pkg::ASM_RELEASE_WAIT_CYC,
    parameter int unsigned STUCK_CYCLES = asm_pkg::ASM_STUCK_CYC
) (
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Static mode pins and device reset pin.
    input wire logic mode_pin_0,
    input wire logic mode_pin_1,
    input wire logic mode_pin_2,
    input wire logic amp_reset_n,
    // PWM inputs A to D.
    input wire logic [3:0] pwm_in,
    // Fault sources from the analog protection circuits.
    input wire logic overtemp_fault,
    input wire logic overload_fault,
    input wire logic supply_fault,
    input wire logic dc_fault,
    input wire logic overtemp_warn,
    // Half-bridge gate controls and weak pulldowns, A to D.
    output logic [3:0] high_side_on,
    output logic [3:0] low_side_on,
    output logic [3:0] weak_pulldown_en,
    // Open-drain fault and warning pins, active low.
    input wire logic fault_n_in,
    output logic fault_n_out,
    output logic fault_n_oe,
    output logic overtemp_warning_n_out,
    output logic overtemp_warning_n_oe
);

    // Counter widths follow the limits, so short simulation limits keep
    // the counters small.
    localparam int SW = $clog2(STUCK_CYCLES + 1);
    localparam int RW = $clog2(RELEASE_WAIT + 1);
    localparam logic [SW-1:0] STUCK_LIM = SW'(STUCK_CYCLES);
    localparam logic [RW-1:0] WAIT_LIM = RW'(RELEASE_WAIT);

    // Every flop of the block lives in this one record.
    typedef struct packed {
        logic [2:0] mode;
        logic rst_q;
        logic fault_lat;
        logic [3:0] pwm_q;
        logic [3:0][SW-1:0] idle;
        logic [3:0] stuck;
        logic [RW-1:0] since_fault;
        logic early;
        logic mute;
        logic dc_en;
        logic [3:0] dis;
        logic [3:0] hs;
        logic [3:0] ls;
        logic [3:0] pd;
        logic fault_oe;
        logic warn_oe;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } asm_state_t;

    asm_state_t st;
    asm_state_t next_st;

    // Source input and inversion for half-bridge hb in the given mode.
    // Bit 2 of the result is the inversion flag, bits 1:0 the input index.
    function automatic logic [2:0] hb_map(logic [2:0] mode, logic [1:0] hb);
        logic [2:0] m;
        m = {1'b0, hb};
        unique case (mode)
            asm_pkg::ASM_BRIDGED_DIFF,
            asm_pkg::ASM_BRIDGED_PAIRED: m = {1'b0, hb};
            asm_pkg::ASM_BRIDGED_SE: m = {hb[0], hb[1], 1'b0};
            asm_pkg::ASM_PARALLEL_DIFF: m = {2'b00, hb[0]};
            asm_pkg::ASM_QUAD_SE: m = {1'b0, hb};
            default: m = {1'b0, hb};
        endcase
        return m;
    endfunction : hb_map

    // Undocumented codes leave every half-bridge off.
    function automatic logic mode_valid(logic [2:0] mode);
        logic v;
        unique case (mode)
            asm_pkg::ASM_BRIDGED_DIFF,
            asm_pkg::ASM_BRIDGED_SE,
            asm_pkg::ASM_BRIDGED_PAIRED,
            asm_pkg::ASM_PARALLEL_DIFF,
            asm_pkg::ASM_QUAD_SE: v = 1'b1;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : mode_valid

    // Mapped offsets; anything else answers with pslverr.
    function automatic logic reg_known(logic [7:0] addr);
        return addr == asm_pkg::ASM_CTRL_ADDR ||
            addr == asm_pkg::ASM_STATUS_ADDR ||
            addr == asm_pkg::ASM_EVENT_ADDR;
    endfunction : reg_known

    logic [2:0] m0;
    logic [2:0] m1;
    logic [2:0] mh;
    logic bridged;
    logic valid;
    logic paired;
    logic rise;
    logic wr;
    logic rd;
    logic [31:0] rv;
    logic bad;
    logic global_off;
    logic in_window;

    always_comb begin
        next_st = st;
        m0 = '0;
        m1 = '0;
        mh = '0;
        bad = 1'b0;
        rv = '0;
        // The mode pins only pass while reset is held low. RULE19 RULE16
        if (!amp_reset_n) begin
            next_st.mode = {mode_pin_2, mode_pin_1, mode_pin_0};
        end
        next_st.rst_q = amp_reset_n;
        // The pin's copy from the last edge turns its level into an edge.
        rise = amp_reset_n && !st.rst_q;
        valid = mode_valid(st.mode); // RULE15
        bridged = st.mode != asm_pkg::ASM_QUAD_SE;
        paired = st.mode == asm_pkg::ASM_BRIDGED_PAIRED;

        // Latched global faults; DC protection is off with paired-state
        // modulation because its idle output is not a zero mean pair.
        if (rise) begin
            next_st.fault_lat = 1'b0; // RULE12
        end
        if (amp_reset_n && (overtemp_fault || overload_fault ||
            (dc_fault && st.dc_en && !paired))) begin // RULE5
            next_st.fault_lat = 1'b1; // RULE17
        end
        // Supply faults clear themselves, so they gate without latching.
        global_off = st.fault_lat || supply_fault || !valid;

        // Missing PWM edges mark an input stuck until it toggles again.
        // The idle count saturates, so a long silence cannot wrap around.
        next_st.pwm_q = pwm_in;
        for (int i = 0; i < 4; i++) begin
            if (pwm_in[i] != st.pwm_q[i]) begin
                next_st.idle[i] = '0;
                next_st.stuck[i] = 1'b0; // RULE18
            end else if (st.idle[i] != STUCK_LIM) begin
                next_st.idle[i] = st.idle[i] + 1'b1;
            end else begin
                next_st.stuck[i] = 1'b1; // RULE18
            end
        end

        // Per half-bridge drive; a stuck input stops its bridged pair as a whole, but
        // a dis bit stops only its own half-bridge, leaving the partner switching.
        for (int i = 0; i < 4; i++) begin
            mh = hb_map(st.mode, 2'(i)); // RULE1 RULE3 RULE4
            m0 = hb_map(st.mode, {1'(i >> 1), 1'b0});
            m1 = hb_map(st.mode, {1'(i >> 1), 1'b1});
            if (bridged) begin
                bad = st.stuck[m0[1:0]] || st.stuck[m1[1:0]]; // RULE14
            end else begin
                bad = st.stuck[mh[1:0]]; // RULE14
            end
            if (st.rst_q && amp_reset_n && !global_off && !st.mute &&
                !st.dis[i] && !bad) begin
                // Single-ended input feeds its inverse to the partner. RULE2
                next_st.hs[i] = st.pwm_q[mh[1:0]] ^ mh[2];
                next_st.ls[i] = !(st.pwm_q[mh[1:0]] ^ mh[2]);
            end else begin
                // Both switches off is the high-impedance state.
                next_st.hs[i] = 1'b0; // RULE8
                next_st.ls[i] = 1'b0; // RULE8
            end
            // Pulldown charges the bootstrap caps in every mode code but quad, parallel and undocumented codes included.
            next_st.pd[i] = !amp_reset_n && bridged; // RULE9 RULE10
        end

        // Fault pin is released while reset is low. RULE11
        next_st.fault_oe = amp_reset_n &&
            (next_st.fault_lat || supply_fault); // RULE17
        // The warning is not latched; it follows the sensor a cycle late.
        next_st.warn_oe = overtemp_warn;

        // Time since the fault pin fell, to flag a too early release.
        if (next_st.fault_oe && !st.fault_oe) begin
            next_st.since_fault = '0;
        end else if (st.since_fault != WAIT_LIM) begin
            next_st.since_fault = st.since_fault + 1'b1;
        end
        // The count saturates at the limit, which also stands for no fault
        // seen since reset, so a first release is never flagged.
        in_window = st.since_fault != WAIT_LIM;

        // APB: one wait state, answer in the second access cycle.
        next_st.ready = psel && penable && !st.ready;
        wr = psel && penable && st.ready && pwrite;
        rd = psel && penable && !st.ready && !pwrite;
        // pslverr stands with pready; an unmapped write changes nothing.
        next_st.err = 1'b0;
        if (psel && penable && !st.ready) begin
            next_st.err = !reg_known(paddr);
        end
        unique case (paddr)
            asm_pkg::ASM_CTRL_ADDR: begin
                rv[asm_pkg::ASM_CTRL_MUTE_BIT] = st.mute;
                rv[asm_pkg::ASM_CTRL_DCEN_BIT] = st.dc_en;
                rv[asm_pkg::ASM_CTRL_DIS_LSB +: 4] = st.dis;
            end
            asm_pkg::ASM_STATUS_ADDR: begin
                rv[asm_pkg::ASM_ST_MODE_LSB +: 3] = st.mode;
                rv[asm_pkg::ASM_ST_VALID_BIT] = valid;
                rv[asm_pkg::ASM_ST_LATCH_BIT] = st.fault_lat;
                rv[asm_pkg::ASM_ST_RUN_BIT] = |(st.hs | st.ls);
                rv[asm_pkg::ASM_ST_FPIN_BIT] = fault_n_in;
                rv[asm_pkg::ASM_ST_STUCK_LSB +: 4] = st.stuck;
            end
            asm_pkg::ASM_EVENT_ADDR: begin
                rv[asm_pkg::ASM_EV_EARLY_BIT] = st.early;
            end
            default: rv = '0;
        endcase
        // Read data stands only in the answer cycle.
        next_st.rdata = rd ? rv : '0;
        if (wr && paddr == asm_pkg::ASM_CTRL_ADDR) begin
            next_st.mute = pwdata[asm_pkg::ASM_CTRL_MUTE_BIT];
            next_st.dc_en = pwdata[asm_pkg::ASM_CTRL_DCEN_BIT];
            next_st.dis = pwdata[asm_pkg::ASM_CTRL_DIS_LSB +: 4];
        end
        if (wr && paddr == asm_pkg::ASM_EVENT_ADDR &&
            pwdata[asm_pkg::ASM_EV_EARLY_BIT]) begin
            next_st.early = 1'b0;
        end
        // A release inside the wait window is recorded; set beats clear.
        if (rise && in_window) begin
            next_st.early = 1'b1; // RULE13
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.since_fault <= WAIT_LIM;
            // Control defaults come from the package reset word.
            st.mute <= asm_pkg::ASM_CTRL_RESET[asm_pkg::ASM_CTRL_MUTE_BIT];
            st.dc_en <= asm_pkg::ASM_CTRL_RESET[asm_pkg::ASM_CTRL_DCEN_BIT];
            st.dis <= asm_pkg::ASM_CTRL_RESET[asm_pkg::ASM_CTRL_DIS_LSB +: 4];
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign high_side_on = st.hs;
    assign low_side_on = st.ls;
    assign weak_pulldown_en = st.pd;
    // Open-drain pins only pull low; the enable carries the level.
    assign fault_n_out = 1'b0;
    assign fault_n_oe = st.fault_oe;
    assign overtemp_warning_n_out = 1'b0;
    assign overtemp_warning_n_oe = st.warn_oe;

endmodule : asm_stage_ctrl

// ===== tb/asm_stage_ctrl_assertions.sv
// Concurrent checks on the stage control ports.
`timescale 1ns/10ps
module asm_stage_chk (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pins in.
    input wire logic mode_pin_0,
    input wire logic mode_pin_1,
    input wire logic mode_pin_2,
    input wire logic amp_reset_n,
    input wire logic overtemp_fault,
    input wire logic overload_fault,
    input wire logic supply_fault,
    input wire logic dc_fault,
    // Pins out.
    input wire logic [3:0] high_side_on,
    input wire logic [3:0] low_side_on,
    input wire logic [3:0] weak_pulldown_en,
    input wire logic fault_n_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [2:0] md = {mode_pin_2, mode_pin_1, mode_pin_0};
    wire oth = overload_fault | overtemp_fault | supply_fault;
    wire off = high_side_on == 4'h0 && low_side_on == 4'h0;

    chk_gates_rst: assert property (!amp_reset_n |=> off)
        else $error("gates on during reset");
    chk_fault_rst: assert property (!amp_reset_n |=> !fault_n_oe)
        else $error("fault pin pulled during reset");
    chk_fault_hold: assert property (overload_fault && amp_reset_n
        ##1 amp_reset_n [*3] |=> fault_n_oe)
        else $error("fault not latched");
    chk_fault_gate: assert property (fault_n_oe |=> off)
        else $error("gates on with fault");
    chk_pd_bridged: assert property (!amp_reset_n && md != 3'b101
        ##1 !amp_reset_n && $stable(md) |=> weak_pulldown_en == 4'hF)
        else $error("pulldown missing in bridged reset");
    chk_pd_quad: assert property (!amp_reset_n && md == 3'b101
        ##1 !amp_reset_n && $stable(md) |=> weak_pulldown_en == 4'h0)
        else $error("pulldown on in quad reset");
    chk_fault_clr: assert property ($rose(amp_reset_n)
        && !oth && !dc_fault |=> !fault_n_oe)
        else $error("latch not cleared on release");
    chk_dc_paired: assert property (amp_reset_n && md == 3'b010
        && $stable(md) && !fault_n_oe && dc_fault && !oth |=> !fault_n_oe)
        else $error("dc protection acted in paired mode");
endmodule : asm_stage_chk

bind asm_stage_ctrl asm_stage_chk u_chk (.pclk, .presetn, .mode_pin_0,
    .mode_pin_1, .mode_pin_2, .amp_reset_n, .overtemp_fault,
    .overload_fault, .supply_fault, .dc_fault, .high_side_on,
    .low_side_on, .weak_pulldown_en, .fault_n_oe);

// ===== tb/asm_pwm_src.sv
// Behavioural PWM modulator feeding the four stage inputs.
`timescale 1ns/10ps
module asm_pwm_src (
    // Clock and control.
    input wire logic clk,
    input wire logic run,
    input wire logic [2:0] mode,
    // PWM lines A to D.
    output logic [3:0] pwm
);
    logic [1:0] cnt = 2'h0;
    // Stopping the count freezes every line, as a stalled modulator would.
    always @(posedge clk) begin
        if (run) begin
            cnt <= cnt + 2'h1;
        end
    end
    always_comb begin
        case (mode)
            3'b010: pwm = {cnt[0], cnt[1], cnt[1], cnt[0]};
            3'b001: pwm = {1'b0, cnt[1], 1'b0, cnt[0]};
            3'b100: pwm = {2'h0, ~cnt[0], cnt[0]};
            default: pwm = {~cnt[1], cnt[1], ~cnt[0], cnt[0]};
        endcase
    end
endmodule : asm_pwm_src

// ===== tb/tb.sv
// Self-checking bench for the stage mode and reset control.
`timescale 1ns/10ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, fault_n_out, fault_n_oe;
    logic [2:0] md = 3'b000;
    logic amp_reset_n = 1'b0;
    logic run = 1'b1;
    logic ovl = 1'b0;
    logic dcf = 1'b0;
    logic [3:0] pwm_in, hs, ls, pd, h1, h2;
    logic [2:0] ml [5] = '{3'b001, 3'b010, 3'b100, 3'b110, 3'b101};
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    // The fault pin has a pull-up, so it reads high when released.
    wire fault_pin = fault_n_oe ? fault_n_out : 1'b1;

    asm_stage_ctrl #(.RELEASE_WAIT(20), .STUCK_CYCLES(8)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_pin_0(md[0]),
        .mode_pin_1(md[1]), .mode_pin_2(md[2]), .amp_reset_n(amp_reset_n),
        .pwm_in(pwm_in), .overtemp_fault(1'b0), .overload_fault(ovl),
        .supply_fault(1'b0), .dc_fault(dcf), .overtemp_warn(1'b0),
        .high_side_on(hs), .low_side_on(ls), .weak_pulldown_en(pd),
        .fault_n_in(fault_pin), .fault_n_out(fault_n_out),
        .fault_n_oe(fault_n_oe), .overtemp_warning_n_out(),
        .overtemp_warning_n_oe());
    asm_pwm_src u_src (.clk(pclk), .run(run), .mode(md), .pwm(pwm_in));

    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        h1 <= pwm_in;
        h2 <= h1;
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end

    function automatic logic [3:0] map(input logic [2:0] m,
            input logic [3:0] p);
        case (m)
            3'b001: map = {~p[2], p[2], ~p[0], p[0]};
            3'b100: map = {p[1], p[0], p[1], p[0]};
            3'b011, 3'b110, 3'b111: map = 4'h0;
            default: map = p;
        endcase
    endfunction : map
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            err_count++;
            $display("unexpected at %0t: got %0h exp %0h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic edges(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : edges
    task automatic run_mode(input logic [2:0] m);
        @(posedge pclk);
        md <= m;
        amp_reset_n <= 1'b0;
        run <= 1'b1;
        edges(4);
        chk(32'(pd), (m == 3'b101) ? 32'h0 : 32'hF);
        @(posedge pclk);
        amp_reset_n <= 1'b1;
        edges(6);
        repeat (8) begin
            edges(1);
            chk(32'(hs), 32'(map(m, h2)));
            chk(32'(ls), 32'(map(m, ~h2)));
        end
        apb(1'b0, asm_pkg::ASM_STATUS_ADDR, 32'h0);
        chk(q & 32'hF, {28'h0, map(m, 4'hF) != 4'h0, m});
    endtask : run_mode
    task automatic t_fault();
        @(posedge pclk);
        ovl <= 1'b1;
        @(posedge pclk);
        ovl <= 1'b0;
        edges(2);
        chk(32'(fault_n_oe), 32'h1);
        chk(32'(hs), 32'h0);
        @(posedge pclk);
        amp_reset_n <= 1'b0;
        edges(3);
        chk(32'(fault_pin), 32'h1);
        @(posedge pclk);
        amp_reset_n <= 1'b1;
        apb(1'b0, asm_pkg::ASM_EVENT_ADDR, 32'h0);
        chk(q, 32'h1);
        apb(1'b1, asm_pkg::ASM_EVENT_ADDR, 32'h1);
        apb(1'b0, asm_pkg::ASM_EVENT_ADDR, 32'h0);
        chk(q, 32'h0);
        edges(1);
        chk(32'(hs), 32'(map(3'b000, h2)));
    endtask : t_fault
    task automatic t_stuck();
        @(posedge pclk);
        run <= 1'b0;
        edges(14);
        chk(32'(hs), 32'h0);
        apb(1'b0, asm_pkg::ASM_STATUS_ADDR, 32'h0);
        chk((q >> 8) & 32'hF, 32'hF);
        @(posedge pclk);
        run <= 1'b1;
        edges(6);
        chk(32'(hs), 32'(map(3'b101, h2)));
    endtask : t_stuck
    task automatic t_dc(input logic x);
        @(posedge pclk);
        dcf <= 1'b1;
        @(posedge pclk);
        dcf <= 1'b0;
        edges(2);
        chk(32'(fault_n_oe), 32'(x));
    endtask : t_dc
    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, asm_pkg::ASM_CTRL_ADDR, 32'h0);
        chk(q, asm_pkg::ASM_CTRL_RESET);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1);
        run_mode(3'b000);
        t_fault();
        foreach (ml[i]) run_mode(ml[i]);
        t_stuck();
        run_mode(3'b010);
        t_dc(1'b0);
        run_mode(3'b000);
        t_dc(1'b1);
        stop_test();
    end
endmodule : tb
